// *** pin_sync.v ***
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes d_i is asynchronous to mclk_i.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter [0:0] INIT = 1'b0
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // Pin and filtered view
  input wire d_i,
  output wire lvl_o,
  output wire rise_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg lvl_r;
  reg rise_r;

  // A change counts only once stages two and three agree
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      lvl_r <= INIT;
      rise_r <= 1'b0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) lvl_r <= s3_r;
      rise_r <= (s2_r == s3_r) & s3_r & ~lvl_r;
    end
  end

  assign lvl_o = lvl_r;
  assign rise_o = rise_r;
endmodule
`default_nettype wire

// *** watchdog_timer_reset_flags.v ***
// Watchdog timer with keyed control, reset-cause flag and AXI4-Lite slave.
// Assumes the chip reset controller acts on the reset request outputs.
//
// Summary of operation
// - Counter ticks on slow oscillator, timeout is a power-of-two division.
// - Key 10101 disables the watchdog, key 01010 enables it.
// - Any other key requests reset after soft delay and sets flag.
// - Control powers up as key 01010 with select 011, running.
// - Select codes 000..110 map to 2^8,10,12,14,15,16,17 periods.
// - Key-triggered reset sets flag bit 0; power-on or writing zero clears it.
// - Overflow while running requests full device reset, sets expiry flag.
// - Overflow in sleep sets expiry and power-down, resets PC and SP.
// - Counter cleared by bad key, clear instruction, halt, selected pin.
// - Select 2^18 gives the longest timeout.
// - Power-on sets port data and control registers to all ones.
// - Power-on loads program counter with zero.
// - Pin reset leaves control and port registers unchanged.
// - Upper four bits of reset-cause register read as zero.
// - Halt sets power-down; power-up or clear instruction clears it.
// - Halt clears counter; counts on only if enabled.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defines.vh"
module watchdog_timer_reset_flags #(
  parameter [15:0] SRESET_CYCLES = `SRESET_CYCLES_DEF
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Device pins and core status
  input wire slow_osc_i,
  input wire ext_clear_n_i,
  input wire pin_reset_sel_i,
  input wire wake_i,
  // Reset requests and state
  output wire device_reset_o,
  output wire pc_sp_reset_o,
  output wire pin_reset_o,
  output wire sleeping_o,
  output wire [7:0] port_data_o,
  output wire [7:0] port_ctrl_o,
  output wire irq_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[7:2] <= `IDX_PCTRL);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] ctrl_r;
  reg wrf_r;
  reg expiry_r;
  reg pdf_r;
  reg sleep_r;
  reg [3:0] istat_r;
  reg [3:0] imask_r;
  reg [7:0] port_data_r;
  reg [7:0] port_ctrl_r;
  reg [15:0] srst_cnt_r;
  reg dev_rst_r;
  reg pcsp_r;
  reg pin_rst_r;
  reg aw_held_r;
  reg [7:0] awaddr_r;
  reg w_held_r;
  reg [7:0] wdata_r;
  reg wlane_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [31:0] rd_nxt;

  wire osc_tick;
  wire pin_lvl;
  wire expire;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .INIT(1'b0)
  ) u_osc_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(slow_osc_i),
    .lvl_o(),
    .rise_o(osc_tick)
  );

  pin_sync #(
    .INIT(1'b1)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(ext_clear_n_i),
    .lvl_o(pin_lvl),
    .rise_o()
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [4:0] key = ctrl_r[`KEY_MSB:`KEY_LSB];
  wire wdt_en = (key == `KEY_ENABLE);
  wire key_bad = ~wdt_en & (key != `KEY_DISABLE);
  wire wr_go = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_ok = wr_go & wlane_r & addr_ok(awaddr_r);
  wire [5:0] widx = awaddr_r[7:2];
  wire wr_ctrl = wr_ok & (widx == `IDX_CTRL);
  wire wr_flags = wr_ok & (widx == `IDX_FLAGS);
  wire wr_istat = wr_ok & (widx == `IDX_ISTAT);
  wire wr_imask = wr_ok & (widx == `IDX_IMASK);
  wire wr_cmd = wr_ok & (widx == `IDX_CMD);
  wire wr_pdata = wr_ok & (widx == `IDX_PDATA);
  wire wr_pctrl = wr_ok & (widx == `IDX_PCTRL);
  wire cmd_clr = wr_cmd & wdata_r[`CMD_CLR_BIT];
  wire cmd_halt = wr_cmd & wdata_r[`CMD_HALT_BIT];
  wire pin_act = ~pin_lvl & pin_reset_sel_i;
  wire pin_evt = pin_act & ~pin_rst_r;
  // Soft reset waits the full delay; a valid key in time cancels it
  wire srst_fire = key_bad & (srst_cnt_r == SRESET_CYCLES - 16'h1);
  wire exp_sleep = expire & sleep_r;
  wire exp_run = expire & ~sleep_r;
  wire dev_rst_nxt = srst_fire | exp_run;
  // Halt is taken as a clear as well: counter restarts from zero
  wire cnt_clr = key_bad | cmd_clr | cmd_halt | pin_act;

  // ----------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------
  wdt_counter u_counter (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick_i(osc_tick),
    .run_i(wdt_en),
    .clear_i(cnt_clr),
    .sel_i(ctrl_r[`SEL_MSB:`SEL_LSB]),
    .expire_o(expire)
  );

  // ----------------------------------------------------------------
  // Control, flags and reset requests
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `CTRL_RESET;
      wrf_r <= 1'b0;
      expiry_r <= 1'b0;
      pdf_r <= 1'b0;
      sleep_r <= 1'b0;
      port_data_r <= `PORT_RESET;
      port_ctrl_r <= `PORT_RESET;
      srst_cnt_r <= 16'h0;
      dev_rst_r <= 1'b0;
      pcsp_r <= 1'b1;
      pin_rst_r <= 1'b0;
    end else begin
      // Reload after a requested reset so the bad key cannot loop
      if (dev_rst_nxt) begin
        ctrl_r <= `CTRL_RESET;
      end else if (wr_ctrl) begin
        ctrl_r <= wdata_r;
      end
      if (key_bad & ~srst_fire) begin
        srst_cnt_r <= srst_cnt_r + 16'h1;
      end else begin
        srst_cnt_r <= 16'h0;
      end
      // Set wins over a clearing write in the same cycle
      if (srst_fire) begin
        wrf_r <= 1'b1;
      end else if (wr_flags & ~wdata_r[`FLAG_WRF_BIT]) begin
        wrf_r <= 1'b0;
      end
      if (expire) begin
        expiry_r <= 1'b1;
      end else if (cmd_clr | cmd_halt) begin
        expiry_r <= 1'b0;
      end
      if (cmd_halt | exp_sleep) begin
        pdf_r <= 1'b1;
      end else if (cmd_clr) begin
        pdf_r <= 1'b0;
      end
      if (cmd_halt) begin
        sleep_r <= 1'b1;
      end else if (wake_i | pin_act | expire) begin
        sleep_r <= 1'b0;
      end
      // Pin reset leaves control and port registers as they are
      if (wr_pdata) begin
        port_data_r <= wdata_r;
      end
      if (wr_pctrl) begin
        port_ctrl_r <= wdata_r;
      end
      dev_rst_r <= dev_rst_nxt;
      pcsp_r <= exp_sleep;
      pin_rst_r <= pin_act;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [3:0] ev;
  assign ev[`IRQ_SWRST] = srst_fire;
  assign ev[`IRQ_EXPIRY] = exp_run;
  assign ev[`IRQ_SLEEP_TO] = exp_sleep;
  assign ev[`IRQ_PIN] = pin_evt;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      istat_r <= 4'h0;
      imask_r <= 4'h0;
    end else begin
      if (wr_istat) begin
        istat_r <= (istat_r & ~wdata_r[3:0]) | ev;
      end else begin
        istat_r <= istat_r | ev;
      end
      if (wr_imask) begin
        imask_r <= wdata_r[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  assign s_axi_awready_o = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready_o = ~w_held_r & ~bvalid_r;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h0;
      w_held_r <= 1'b0;
      wdata_r <= 8'h0;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata_i[7:0];
        wlane_r <= s_axi_wstrb_i[0];
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready_o = ~rvalid_r;

  always @* begin
    rd_nxt = 32'h0;
    case (s_axi_araddr_i[7:2])
      `IDX_CTRL: rd_nxt[7:0] = ctrl_r;
      `IDX_FLAGS: rd_nxt[0] = wrf_r;
      `IDX_ISTAT: rd_nxt[3:0] = istat_r;
      `IDX_IMASK: rd_nxt[3:0] = imask_r;
      `IDX_PSTAT: rd_nxt[3:0] = {wdt_en, sleep_r, pdf_r, expiry_r};
      `IDX_PDATA: rd_nxt[7:0] = port_data_r;
      `IDX_PCTRL: rd_nxt[7:0] = port_ctrl_r;
      default: rd_nxt = 32'h0;
    endcase
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i & ~rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_nxt;
        rresp_r <= addr_ok(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign device_reset_o = dev_rst_r;
  assign pc_sp_reset_o = pcsp_r;
  assign pin_reset_o = pin_rst_r;
  assign sleeping_o = sleep_r;
  assign port_data_o = port_data_r;
  assign port_ctrl_o = port_ctrl_r;
  assign irq_o = |(istat_r & imask_r);

endmodule
`default_nettype wire

// *** watchdog_timer_reset_flags_properties.sv ***
// Checker for the watchdog block: bus handshakes and reset outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer_reset_flags_properties (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Bus
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Core
  input wire logic pin_reset_sel_i,
  input wire logic wake_i,
  input wire logic device_reset_o,
  input wire logic pc_sp_reset_o,
  input wire logic pin_reset_o,
  input wire logic sleeping_o,
  input wire logic [7:0] port_data_o,
  input wire logic [7:0] port_ctrl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_pc_zero: assert property ($rose(rst_n_i) |-> pc_sp_reset_o)
    else $error("program counter load missing after reset");
  a_ports_high: assert property ($rose(rst_n_i) |-> port_data_o == 8'hff &&
    port_ctrl_o == 8'hff) else $error("ports not all ones after reset");
  a_dev_pulse: assert property (device_reset_o |=> !device_reset_o)
    else $error("device reset longer than one cycle");
  a_reset_kinds: assert property (!(device_reset_o && pc_sp_reset_o))
    else $error("both reset kinds at once");
  a_pin_select: assert property (pin_reset_o |-> $past(pin_reset_sel_i))
    else $error("pin reset while pin not selected");
  a_wake_exit: assert property (sleeping_o && wake_i |=> !sleeping_o)
    else $error("sleep kept after wake");
  a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_write_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o &&
    !s_axi_wready_o) else $error("write accepted during response");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o) else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
endmodule

bind watchdog_timer_reset_flags watchdog_timer_reset_flags_properties u_props (
  .mclk_i, .rst_n_i, .s_axi_awready_o, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .pin_reset_sel_i, .wake_i, .device_reset_o, .pc_sp_reset_o,
  .pin_reset_o, .sleeping_o, .port_data_o, .port_ctrl_o);
`default_nettype wire

// *** watchdog_timer_reset_flags_tb.sv ***
// Directed testbench for the watchdog block over its register bus.
// Assumes the design, its defines header and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defines.vh"
module watchdog_timer_reset_flags_tb;
  localparam [7:0] A_CTRL = {`IDX_CTRL, 2'b00};
  localparam [7:0] A_FLAGS = {`IDX_FLAGS, 2'b00};
  localparam [7:0] A_ISTAT = {`IDX_ISTAT, 2'b00};
  localparam [7:0] A_IMASK = {`IDX_IMASK, 2'b00};
  localparam [7:0] A_PSTAT = {`IDX_PSTAT, 2'b00};
  localparam [7:0] A_CMD = {`IDX_CMD, 2'b00};
  localparam [7:0] A_PDATA = {`IDX_PDATA, 2'b00};
  localparam [7:0] A_PCTRL = {`IDX_PCTRL, 2'b00};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00;
  logic [7:0] s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'h0;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic slow_osc_i = 1'b0;
  logic ext_clear_n_i = 1'b1;
  logic pin_reset_sel_i = 1'b0;
  logic wake_i = 1'b0;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire device_reset_o, pc_sp_reset_o, pin_reset_o, sleeping_o, irq_o;
  wire [7:0] port_data_o, port_ctrl_o;
  logic [31:0] rdat;
  logic [1:0] resp;
  int fail_count = 0;
  int n_compared = 0;
  int ticks = 0;
  int osc_div = 0;
  int n_dev = 0;
  int n_pcsp = 0;
  int s, p, t0, e;

  // Short soft reset delay keeps the bad-key test brief
  watchdog_timer_reset_flags #(.SRESET_CYCLES(16'h0008)) dut (
    .mclk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .slow_osc_i,
    .ext_clear_n_i, .pin_reset_sel_i, .wake_i, .device_reset_o, .pc_sp_reset_o,
    .pin_reset_o, .sleeping_o, .port_data_o, .port_ctrl_o, .irq_o);

  // ----------------------------------------------------------------
  // Clock, slow oscillator and event counters
  // ----------------------------------------------------------------
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // Oscillator runs 20 mclk per period so short divisions finish quickly
  always @(posedge mclk_i) begin
    osc_div <= (osc_div == 9) ? 0 : osc_div + 1;
    if (osc_div == 9) begin
      slow_osc_i <= ~slow_osc_i;
      if (!slow_osc_i) ticks <= ticks + 1;
    end
    if (device_reset_o === 1'b1) n_dev <= n_dev + 1;
    if (pc_sp_reset_o === 1'b1) n_pcsp <= n_pcsp + 1;
  end

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_wstrb_i <= 4'hf;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      k++;
    end while (s_axi_bvalid_o !== 1'b1 && k < 100);
    resp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    chk(k < 100, 1);
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      k++;
    end while (s_axi_rvalid_o !== 1'b1 && k < 100);
    rdat = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    chk(k < 100, 1);
  endtask

  task automatic wait_ev(input int lim);
    int c;
    c = n_dev + n_pcsp;
    for (int k = 0; k < lim && n_dev + n_pcsp == c; k++) @(posedge mclk_i);
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Longest path is about 40k cycles; a 90k-cycle limit leaves margin
  initial begin
    #900000;
    fail_count++;
    $display("Error at %0t: run timed out", $time);
    stop_test;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(A_CTRL); chk(rdat, 32'h53);
    rd(A_PDATA); chk(rdat, 32'hff);
    rd(A_PCTRL); chk(rdat, 32'hff);
    wr(A_FLAGS, 8'hff); rd(A_FLAGS); chk(rdat, 32'h0);
    rd(A_PSTAT); chk(rdat, 32'h08);
    rd(8'h20); chk(resp, `RESP_SLVERR);
    wr(8'h20, 8'h01); chk(resp, `RESP_SLVERR);
    $display("Test reset values done");
    for (int i = 0; i < 2; i++) begin
      e = i ? (1 << `TO_EXP1) : (1 << `TO_EXP0);
      wr(A_CMD, 8'h01);
      t0 = ticks;
      s = n_dev;
      wr(A_CTRL, {`KEY_ENABLE, i[2:0]});
      wait_ev(30000);
      chk(n_dev - s, 1);
      chk(ticks - t0 >= e - 2 && ticks - t0 <= e + 2, 1);
      rd(A_PSTAT); chk(rdat, 32'h09);
      rd(A_CTRL); chk(rdat, 32'h53);
    end
    $display("Test timeout periods done");
    wr(A_CMD, 8'h01);
    wr(A_CTRL, {`KEY_DISABLE, 3'b000});
    rd(A_PSTAT); chk(rdat, 32'h00);
    s = n_dev;
    repeat (6000) @(posedge mclk_i);
    chk(n_dev - s, 0);
    wr(A_CTRL, {`KEY_ENABLE, 3'b000});
    rd(A_PSTAT); chk(rdat, 32'h08);
    $display("Test key disable done");
    s = n_dev;
    p = n_pcsp;
    t0 = ticks;
    wr(A_CMD, 8'h02);
    rd(A_PSTAT); chk(rdat, 32'h0e);
    wait_ev(6000);
    chk(n_pcsp - p, 1);
    chk(n_dev - s, 0);
    chk(ticks - t0 >= 254 && ticks - t0 <= 258, 1);
    rd(A_PSTAT); chk(rdat, 32'h0b);
    wr(A_CMD, 8'h01);
    rd(A_PSTAT); chk(rdat, 32'h08);
    wr(A_CMD, 8'h02);
    chk(sleeping_o, 1);
    wake_i <= 1'b1;
    @(posedge mclk_i);
    wake_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk(sleeping_o, 0);
    $display("Test halt and sleep done");
    s = n_dev;
    wr(A_CTRL, 8'h00);
    wait_ev(100);
    chk(n_dev - s, 1);
    chk(irq_o, 0);
    rd(A_FLAGS); chk(rdat, 32'h01);
    rd(A_CTRL); chk(rdat, 32'h53);
    wr(A_IMASK, 8'h01);
    chk(irq_o, 1);
    wr(A_FLAGS, 8'h01); rd(A_FLAGS); chk(rdat, 32'h01);
    wr(A_FLAGS, 8'h00); rd(A_FLAGS); chk(rdat, 32'h00);
    wr(A_ISTAT, 8'h01);
    chk(irq_o, 0);
    $display("Test bad key and interrupt done");
    wr(A_CTRL, 8'h54);
    wr(A_PDATA, 8'h3c);
    for (int i = 1; i >= 0; i--) begin
      pin_reset_sel_i <= i[0];
      ext_clear_n_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      chk(pin_reset_o, i);
      ext_clear_n_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
      chk(pin_reset_o, 0);
    end
    rd(A_CTRL); chk(rdat, 32'h54);
    rd(A_PDATA); chk(rdat, 32'h3c);
    $display("Test pin reset done");
    stop_test;
  end
endmodule
`default_nettype wire

// *** wdt_counter.v ***
// Watchdog divider counting slow-oscillator ticks up to a power of two.
// Assumes tick_i is a one-cycle pulse per oscillator period.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defines.vh"
module wdt_counter (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // Control
  input wire tick_i,
  input wire run_i,
  input wire clear_i,
  input wire [2:0] sel_i,
  // Status
  output wire expire_o
);
  reg [17:0] cnt_r;
  reg expire_r;

  // Last count before expiry: 2^exp - 1; exp 18 wraps to all ones
  function [17:0] last_cnt;
    input [2:0] sel;
    reg [4:0] e;
    begin
      e = `TO_EXP7;
      case (sel)
        3'h0: e = `TO_EXP0;
        3'h1: e = `TO_EXP1;
        3'h2: e = `TO_EXP2;
        3'h3: e = `TO_EXP3;
        3'h4: e = `TO_EXP4;
        3'h5: e = `TO_EXP5;
        3'h6: e = `TO_EXP6;
        default: e = `TO_EXP7;
      endcase
      last_cnt = (18'h1 << e) - 18'h1;
    end
  endfunction

  // A shorter select taken with the count at or past its last count expires at the next tick
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 18'h0;
      expire_r <= 1'b0;
    end else if (clear_i) begin
      cnt_r <= 18'h0;
      expire_r <= 1'b0;
    end else if (run_i & tick_i) begin
      if (cnt_r >= last_cnt(sel_i)) begin
        cnt_r <= 18'h0;
        expire_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 18'h1;
        expire_r <= 1'b0;
      end
    end else begin
      expire_r <= 1'b0;
    end
  end

  assign expire_o = expire_r;
endmodule
`default_nettype wire

// *** wdt_defines.vh ***
// Constants for the watchdog timer with reset-cause flags.
// Assumes the includer uses `define names only; no logic lives here.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// ----------------------------------------------------------------
// Register word indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTRL 6'h00
`define IDX_FLAGS 6'h01
`define IDX_ISTAT 6'h02
`define IDX_IMASK 6'h03
`define IDX_PSTAT 6'h04
`define IDX_CMD 6'h05
`define IDX_PDATA 6'h06
`define IDX_PCTRL 6'h07

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define KEY_MSB 7
`define KEY_LSB 3
`define SEL_MSB 2
`define SEL_LSB 0
`define KEY_DISABLE 5'h15
`define KEY_ENABLE 5'h0a
`define CTRL_RESET 8'h53
`define PORT_RESET 8'hff
`define FLAG_WRF_BIT 0
`define CMD_CLR_BIT 0
`define CMD_HALT_BIT 1
`define IRQ_SWRST 0
`define IRQ_EXPIRY 1
`define IRQ_SLEEP_TO 2
`define IRQ_PIN 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timeout exponents per select code, and timing
// ----------------------------------------------------------------
`define TO_EXP0 5'd8
`define TO_EXP1 5'd10
`define TO_EXP2 5'd12
`define TO_EXP3 5'd14
`define TO_EXP4 5'd15
`define TO_EXP5 5'd16
`define TO_EXP6 5'd17
`define TO_EXP7 5'd18
// Soft reset delay in mclk cycles: 64 us of the 100 MHz clock
`define SRESET_CYCLES_DEF 16'd6400

`endif
